// ===== src/dsp_decode_pkg.sv
// Package: instruction field layout and codes
`default_nettype none
package dsp_decode_pkg;
  // ==========================================================================
  // Instruction word layout
  localparam int INSTR_W = 24;
  localparam int DATA_W = 16;
  localparam int PC_W = 11;
  localparam int RP_W = 10;
  localparam int DP_W = 8;
  localparam int TYPE_HI = 23;
  localparam int TYPE_LO = 22;
  localparam logic [1:0] TYPE_OP = 2'h0;
  localparam logic [1:0] TYPE_RT = 2'h1;
  localparam logic [1:0] TYPE_JP = 2'h2;
  localparam logic [1:0] TYPE_LD = 2'h3;
  localparam int ASL_BIT = 15;
  localparam int DPL_HI = 14;
  localparam int DPL_LO = 13;
  localparam int DPH_HI = 12;
  localparam int DPH_LO = 9;
  localparam int RPD_BIT = 8;
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 4;
  localparam int DST_HI = 3;
  localparam int DST_LO = 0;
  localparam int BR_HI = 21;
  localparam int BR_LO = 19;
  localparam int COND_HI = 18;
  localparam int COND_LO = 13;
  localparam int NA_HI = 12;
  localparam int NA_LO = 2;
  localparam int IMM_HI = 21;
  localparam int IMM_LO = 6;
  localparam int DP_LOW_HI = 3;
  localparam int DP_HIGH_LO = 4;
  localparam int DP_BANK_BIT = 6;
  // ==========================================================================
  // Branch class codes
  localparam logic [2:0] BR_JUMP = 3'h4;
  localparam logic [2:0] BR_CALL = 3'h5;
  localparam logic [2:0] BR_COND = 3'h2;
  // Low pointer operations
  localparam logic [1:0] DPL_NOP = 2'h0;
  localparam logic [1:0] DPL_INC = 2'h1;
  localparam logic [1:0] DPL_DEC = 2'h2;
  localparam logic [1:0] DPL_CLR = 2'h3;
  // ==========================================================================
  // Source codes
  localparam logic [3:0] SRC_TRB = 4'h0;
  localparam logic [3:0] SRC_ACCUMULATOR_A = 4'h1;
  localparam logic [3:0] SRC_ACCUMULATOR_B = 4'h2;
  localparam logic [3:0] SRC_TR = 4'h3;
  localparam logic [3:0] SRC_DP = 4'h4;
  localparam logic [3:0] SRC_RP = 4'h5;
  localparam logic [3:0] SRC_ROM = 4'h6;
  localparam logic [3:0] SRC_SGN = 4'h7;
  localparam logic [3:0] SRC_HOST = 4'h8;
  localparam logic [3:0] SRC_HOSTQ = 4'h9;
  localparam logic [3:0] SRC_STAT = 4'hA;
  localparam logic [3:0] SRC_SIM = 4'hB;
  localparam logic [3:0] SRC_SIL = 4'hC;
  localparam logic [3:0] SRC_K = 4'hD;
  localparam logic [3:0] SRC_L = 4'hE;
  localparam logic [3:0] SRC_RAM = 4'hF;
  // Destination codes
  localparam logic [3:0] DST_NONE = 4'h0;
  localparam logic [3:0] DST_ACCUMULATOR_A = 4'h1;
  localparam logic [3:0] DST_ACCUMULATOR_B = 4'h2;
  localparam logic [3:0] DST_TR = 4'h3;
  localparam logic [3:0] DST_DP = 4'h4;
  localparam logic [3:0] DST_RP = 4'h5;
  localparam logic [3:0] DST_HOST = 4'h6;
  localparam logic [3:0] DST_STAT = 4'h7;
  localparam logic [3:0] DST_SOL = 4'h8;
  localparam logic [3:0] DST_SOM = 4'h9;
  localparam logic [3:0] DST_K = 4'hA;
  localparam logic [3:0] DST_KLR = 4'hB;
  localparam logic [3:0] DST_KLM = 4'hC;
  localparam logic [3:0] DST_L = 4'hD;
  localparam logic [3:0] DST_TRB = 4'hE;
  localparam logic [3:0] DST_RAM = 4'hF;
  // Status word bits
  localparam int STAT_RQM_BIT = 15;
  localparam int STAT_DMA_BIT = 11;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage
`default_nettype wire

// ===== src/dsp_pointer_unit.sv
// Pointer modification unit
`default_nettype none
module dsp_pointer_unit #(
  parameter int DP_W = dsp_decode_pkg::DP_W,
  parameter int RP_W = dsp_decode_pkg::RP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic step,
  input wire logic [1:0] pointer_low_op,
  input wire logic [3:0] pointer_high_mask,
  input wire logic rom_pointer_step,
  input wire logic load_dp,
  input wire logic load_rp,
  input wire logic [15:0] bus_value,
  // Pointers
  output logic [DP_W-1:0] data_pointer,
  output logic [RP_W-1:0] rom_pointer
);
  logic [3:0] low_nibble;
  logic [3:0] next_low;

  // ==========================================================================
  // Low pointer arithmetic on bits 3..0
  assign low_nibble = data_pointer[dsp_decode_pkg::DP_LOW_HI:0];
  always_comb
  begin
    case (pointer_low_op)
      dsp_decode_pkg::DPL_INC: next_low = low_nibble + 4'h1;
      dsp_decode_pkg::DPL_DEC: next_low = low_nibble - 4'h1;
      dsp_decode_pkg::DPL_CLR: next_low = 4'h0;
      default: next_low = low_nibble;
    endcase
  end

  // Data pointer: a bus move wins over modification; applied at cycle end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      data_pointer <= '0;
    else if (load_dp)
      data_pointer <= bus_value[DP_W-1:0];
    else if (step)
      data_pointer <= {data_pointer[7:4] ^ pointer_high_mask, next_low};
  end

  // ROM pointer step
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rom_pointer <= '0;
    else if (load_rp)
      rom_pointer <= bus_value[RP_W-1:0];
    else if (step && rom_pointer_step)
      rom_pointer <= rom_pointer - RP_W'(1);
  end
endmodule
`default_nettype wire

// ===== src/dsp_instruction_field_decoder.sv
// Instruction decoder and data-move core
// ============================================================================
// Behaviour
// - Branch bits 100 jump, 101 call, 010 conditional jump.
// - Taken branch loads PC from next address, else PC plus one.
// - Load-immediate writes 16-bit value to destination-coded register.
// - Low pointer op: keep, increment, decrement or clear bits 3..0.
// - High mask is XORed into data pointer bits 7..4.
// - ROM pointer step bit 1 decrements ROM pointer by one.
// - Source code selects which register drives the internal bus.
// - Source code 0 still drives temp register B onto the bus.
// - Quiet host read sets neither request flag nor DMA request.
// - MSB-first serial read: first received bit lands in MSB.
// - Reversed serial read: first received bit lands in LSB.
// - Destination code routes the bus value to the selected target.
// - LSB-first serial out shifts least significant bit first.
// - MSB-first serial out shifts most significant bit first.
// - Dual bus/ROM load: bus to factor one, ROM to factor two.
// - Dual RAM/bus load: RAM at pointer with bit 6 set, bus to two.
// - Accumulator both ALU target and move destination: ALU suppressed.
// - Pointer changes apply at cycle end after the move used them.
// - Internal host data access sets request flag; host access clears.
`default_nettype none
module dsp_instruction_field_decoder #(
  parameter int DATA_W = dsp_decode_pkg::DATA_W,
  parameter int PC_W = dsp_decode_pkg::PC_W,
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction stream
  input wire logic [23:0] instruction,
  input wire logic instr_valid,
  input wire logic condition_true,
  output logic [PC_W-1:0] program_counter,
  output logic call_push,
  // ROM data port, addressed by the ROM pointer
  input wire logic [15:0] rom_data,
  output logic [9:0] rom_pointer,
  // ALU result and select
  input wire logic [15:0] alu_result,
  input wire logic alu_op_active,
  output logic accumulator_select,
  output logic alu_enable,
  // Host side of the host data register
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_data_reg,
  output logic host_request_flag,
  output logic dma_request,
  // Serial input word, filled first bit at bit 0 onward
  input wire logic [15:0] serial_in_word,
  input wire logic [3:0] serial_in_count,
  // Serial output
  output logic [15:0] serial_out_word,
  output logic serial_out_load,
  output logic serial_out_lsb_first,
  // Visible state
  output logic [15:0] internal_bus,
  output logic [15:0] accumulator_a,
  output logic [15:0] accumulator_b,
  output logic [15:0] factor_one,
  output logic [15:0] factor_two,
  output logic [15:0] status_reg,
  output logic [7:0] data_pointer
);
  // ==========================================================================
  // Field extraction
  logic [1:0] instr_type;
  logic [2:0] branch_code;
  logic [PC_W-1:0] next_address;
  logic [15:0] immediate_value;
  logic [1:0] pointer_low_op;
  logic [3:0] pointer_high_mask;
  logic rom_pointer_step;
  logic [3:0] source_select;
  logic [3:0] dest_select;
  logic is_op;
  logic is_ld;
  logic is_jp;
  logic [15:0] temp_reg_a;
  logic [15:0] temp_reg_b;
  logic [15:0] sign_reg;
  logic [15:0] move_value;
  logic [15:0] serial_in_msb_first;
  logic [15:0] serial_in_reversed;
  logic [15:0] ram [RAM_DEPTH];
  logic [7:0] bank_address;
  logic move_dst_acc;
  logic host_internal_access;

  assign instr_type = instruction[dsp_decode_pkg::TYPE_HI:dsp_decode_pkg::TYPE_LO];
  assign is_op = instr_valid && (instr_type == dsp_decode_pkg::TYPE_OP || instr_type == dsp_decode_pkg::TYPE_RT);
  assign is_ld = instr_valid && instr_type == dsp_decode_pkg::TYPE_LD;
  assign is_jp = instr_valid && instr_type == dsp_decode_pkg::TYPE_JP;
  assign branch_code = instruction[dsp_decode_pkg::BR_HI:dsp_decode_pkg::BR_LO];
  assign next_address = instruction[dsp_decode_pkg::NA_HI:dsp_decode_pkg::NA_LO];
  assign immediate_value = instruction[dsp_decode_pkg::IMM_HI:dsp_decode_pkg::IMM_LO];
  assign accumulator_select = instruction[dsp_decode_pkg::ASL_BIT];
  assign pointer_low_op = instruction[dsp_decode_pkg::DPL_HI:dsp_decode_pkg::DPL_LO];
  assign pointer_high_mask = instruction[dsp_decode_pkg::DPH_HI:dsp_decode_pkg::DPH_LO];
  assign rom_pointer_step = instruction[dsp_decode_pkg::RPD_BIT];
  assign source_select = instruction[dsp_decode_pkg::SRC_HI:dsp_decode_pkg::SRC_LO];
  // Load-immediate shares the destination encoding of the operation form
  assign dest_select = (is_op || is_ld) ? instruction[dsp_decode_pkg::DST_HI:dsp_decode_pkg::DST_LO]
                                        : dsp_decode_pkg::DST_NONE;

  // Bit reversal used by the MSB-first serial view only
  function automatic logic [15:0] reverse16(input logic [15:0] value);
    for (int i = 0; i < 16; i++)
      reverse16[i] = value[15-i];
  endfunction

  // ==========================================================================
  // Serial input views; the shifter fills bit 0 first
  assign serial_in_reversed = serial_in_word;
  assign serial_in_msb_first = reverse16(serial_in_word);

  // Source mux; code 0 is never an idle bus
  always_comb
  begin
    case (source_select)
      dsp_decode_pkg::SRC_TRB: move_value = temp_reg_b;
      dsp_decode_pkg::SRC_ACCUMULATOR_A: move_value = accumulator_a;
      dsp_decode_pkg::SRC_ACCUMULATOR_B: move_value = accumulator_b;
      dsp_decode_pkg::SRC_TR: move_value = temp_reg_a;
      dsp_decode_pkg::SRC_DP: move_value = {8'h00, data_pointer};
      dsp_decode_pkg::SRC_RP: move_value = {6'h00, rom_pointer};
      dsp_decode_pkg::SRC_ROM: move_value = rom_data;
      dsp_decode_pkg::SRC_SGN: move_value = sign_reg;
      dsp_decode_pkg::SRC_HOST: move_value = host_data_reg;
      dsp_decode_pkg::SRC_HOSTQ: move_value = host_data_reg;
      dsp_decode_pkg::SRC_STAT: move_value = status_reg;
      dsp_decode_pkg::SRC_SIM: move_value = serial_in_msb_first;
      dsp_decode_pkg::SRC_SIL: move_value = serial_in_reversed;
      dsp_decode_pkg::SRC_K: move_value = factor_one;
      dsp_decode_pkg::SRC_L: move_value = factor_two;
      default: move_value = ram[data_pointer];
    endcase
  end

  // Load-immediate drives its value onto the bus
  assign internal_bus = is_ld ? immediate_value : (is_op ? move_value : dsp_decode_pkg::DATA_ZERO);

  // ==========================================================================
  // ALU suppression when the selected accumulator is also the move target
  assign move_dst_acc = (dest_select == dsp_decode_pkg::DST_ACCUMULATOR_A && !accumulator_select) ||
                        (dest_select == dsp_decode_pkg::DST_ACCUMULATOR_B && accumulator_select);
  assign alu_enable = is_op && alu_op_active && !move_dst_acc;

  // Accumulators: the move supersedes the ALU result
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      accumulator_a <= dsp_decode_pkg::DATA_ZERO;
    else if (dest_select == dsp_decode_pkg::DST_ACCUMULATOR_A)
      accumulator_a <= internal_bus;
    else if (alu_enable && !accumulator_select)
      accumulator_a <= alu_result;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      accumulator_b <= dsp_decode_pkg::DATA_ZERO;
    else if (dest_select == dsp_decode_pkg::DST_ACCUMULATOR_B)
      accumulator_b <= internal_bus;
    else if (alu_enable && accumulator_select)
      accumulator_b <= alu_result;
  end

  // Sign of the last ALU result on A
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sign_reg <= dsp_decode_pkg::DATA_ZERO;
    else if (alu_enable && !accumulator_select)
      sign_reg <= {16{alu_result[DATA_W-1]}};
  end

  // Temporary registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      temp_reg_a <= dsp_decode_pkg::DATA_ZERO;
      temp_reg_b <= dsp_decode_pkg::DATA_ZERO;
    end
    else
    begin
      if (dest_select == dsp_decode_pkg::DST_TR)
        temp_reg_a <= internal_bus;
      if (dest_select == dsp_decode_pkg::DST_TRB)
        temp_reg_b <= internal_bus;
    end
  end

  // ==========================================================================
  // Multiplier factors and dual loads
  assign bank_address = {data_pointer[7], 1'b1, data_pointer[5:0]};
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      factor_one <= dsp_decode_pkg::DATA_ZERO;
      factor_two <= dsp_decode_pkg::DATA_ZERO;
    end
    else
    begin
      case (dest_select)
        dsp_decode_pkg::DST_K: factor_one <= internal_bus;
        dsp_decode_pkg::DST_L: factor_two <= internal_bus;
        dsp_decode_pkg::DST_KLR:
        begin
          factor_one <= internal_bus;
          factor_two <= rom_data;
        end
        dsp_decode_pkg::DST_KLM:
        begin
          factor_one <= ram[bank_address];
          factor_two <= internal_bus;
        end
        default:
        begin
          factor_one <= factor_one;
          factor_two <= factor_two;
        end
      endcase
    end
  end

  // Data RAM, written at the pre-update pointer
  always_ff @(posedge clk)
  begin
    if (dest_select == dsp_decode_pkg::DST_RAM)
      ram[data_pointer] <= internal_bus;
  end

  // ==========================================================================
  // Host data register and request flag; the set wins over a host clear
  assign host_internal_access = (is_op && source_select == dsp_decode_pkg::SRC_HOST) ||
                                dest_select == dsp_decode_pkg::DST_HOST;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      host_data_reg <= dsp_decode_pkg::DATA_ZERO;
    else if (dest_select == dsp_decode_pkg::DST_HOST)
      host_data_reg <= internal_bus;
    else if (host_write)
      host_data_reg <= host_wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      host_request_flag <= 1'b0;
    else if (host_internal_access)
      host_request_flag <= 1'b1;
    else if (host_write || host_read)
      host_request_flag <= 1'b0;
  end

  // DMA request follows the flag only in DMA mode
  assign dma_request = host_request_flag && status_reg[dsp_decode_pkg::STAT_DMA_BIT];

  // Status word; the request bit copies the flag one cycle later
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_reg <= dsp_decode_pkg::STAT_RESET;
    else if (dest_select == dsp_decode_pkg::DST_STAT)
      status_reg <= {host_request_flag, internal_bus[14:0]};
    else
      status_reg[dsp_decode_pkg::STAT_RQM_BIT] <= host_request_flag;
  end

  // ==========================================================================
  // Serial output staging
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_out_word <= dsp_decode_pkg::DATA_ZERO;
      serial_out_load <= 1'b0;
      serial_out_lsb_first <= 1'b0;
    end
    else
    begin
      serial_out_load <= dest_select == dsp_decode_pkg::DST_SOL || dest_select == dsp_decode_pkg::DST_SOM;
      if (dest_select == dsp_decode_pkg::DST_SOL)
      begin
        serial_out_word <= internal_bus;
        serial_out_lsb_first <= 1'b1;
      end
      else if (dest_select == dsp_decode_pkg::DST_SOM)
      begin
        serial_out_word <= internal_bus;
        serial_out_lsb_first <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Program counter and branch classes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      program_counter <= '0;
      call_push <= 1'b0;
    end
    else
    begin
      call_push <= is_jp && branch_code == dsp_decode_pkg::BR_CALL;
      if (is_jp && (branch_code == dsp_decode_pkg::BR_JUMP || branch_code == dsp_decode_pkg::BR_CALL ||
                    (branch_code == dsp_decode_pkg::BR_COND && condition_true)))
        program_counter <= next_address;
      else if (instr_valid)
        program_counter <= program_counter + PC_W'(1);
    end
  end

  // Pointer unit, updated after the move
  dsp_pointer_unit u_pointers (
    .clk(clk),
    .rstn(rstn),
    .step(is_op),
    .pointer_low_op(pointer_low_op),
    .pointer_high_mask(pointer_high_mask),
    .rom_pointer_step(rom_pointer_step),
    .load_dp(dest_select == dsp_decode_pkg::DST_DP),
    .load_rp(dest_select == dsp_decode_pkg::DST_RP),
    .bus_value(internal_bus),
    .data_pointer(data_pointer),
    .rom_pointer(rom_pointer)
  );

  logic unused_count;
  assign unused_count = ^serial_in_count;
endmodule
`default_nettype wire

// ===== sim/dsp_instruction_field_decoder_props.sv
// Port checks of the instruction decoder
`default_nettype none
module dsp_decode_props #(
  parameter int PC_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction side
  input wire logic [23:0] instruction,
  input wire logic instr_valid,
  input wire logic alu_op_active,
  input wire logic host_write,
  // Watched outputs
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [9:0] rom_pointer,
  input wire logic accumulator_select,
  input wire logic alu_enable,
  input wire logic host_request_flag,
  input wire logic serial_out_load,
  input wire logic serial_out_lsb_first,
  input wire logic [15:0] internal_bus,
  input wire logic [15:0] accumulator_a,
  input wire logic [7:0] data_pointer
);
  // ==========================================================================
  // Instruction classes
  wire logic go_op = instr_valid && instruction[23:22] == 2'h0;
  wire logic go_jp = instr_valid && instruction[23:22] == 2'h2;
  wire logic go_ld = instr_valid && instruction[23:22] == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Serial word loads
  sequence ld_sol;
    go_ld && instruction[3:0] == 4'h8;
  endsequence
  sequence ld_som;
    go_ld && instruction[3:0] == 4'h9;
  endsequence
  // ==========================================================================
  // Properties
  acc_pick_a: assert property (go_op |-> accumulator_select == instruction[15])
    else $error("acc select wrong");
  alu_mute_a: assert property (go_op && alu_op_active && !instruction[15] && instruction[3:0] == 4'h1 |-> !alu_enable)
    else $error("ALU not muted");
  pc_step_a: assert property (go_op |=> program_counter == $past(program_counter) + 1'b1)
    else $error("PC did not step");
  jump_take_a: assert property (go_jp && instruction[21:19] == 3'h4 |=> program_counter == $past(instruction[12:2]))
    else $error("jump not taken");
  imm_bus_a: assert property (go_ld |-> internal_bus == instruction[21:6])
    else $error("bus lacks immediate");
  src_acc_a: assert property (go_op && instruction[7:4] == 4'h1 |-> internal_bus == accumulator_a)
    else $error("bus lacks acc A");
  rom_down_a: assert property (go_op && instruction[8] && instruction[3:0] != 4'h5 |=> rom_pointer == $past(rom_pointer) - 1'b1)
    else $error("RP not decremented");
  low_clear_a: assert property (go_op && instruction[14:13] == 2'h3 && instruction[3:0] != 4'h4 |=> data_pointer[3:0] == 4'h0)
    else $error("DP low not cleared");
  high_mask_a: assert property (go_op && instruction[3:0] != 4'h4 |=> data_pointer[7:4] == ($past(data_pointer[7:4]) ^ $past(instruction[12:9])))
    else $error("DP high not masked");
  quiet_read_a: assert property (go_op && instruction[7:4] == 4'h9 && instruction[3:0] != 4'h6 && !host_request_flag
    |=> !host_request_flag)
    else $error("quiet read set flag");
  serial_lsb_a: assert property (ld_sol |=> serial_out_load && serial_out_lsb_first)
    else $error("bad LSB-first load");
  serial_msb_a: assert property (ld_som |=> serial_out_load && !serial_out_lsb_first)
    else $error("bad MSB-first load");
endmodule
bind dsp_instruction_field_decoder dsp_decode_props #(.PC_W(PC_W)) dsp_decode_props_i (.clk(clk), .rstn(rstn),
  .instruction(instruction), .instr_valid(instr_valid), .alu_op_active(alu_op_active), .host_write(host_write),
  .program_counter(program_counter), .rom_pointer(rom_pointer), .accumulator_select(accumulator_select),
  .alu_enable(alu_enable), .host_request_flag(host_request_flag), .serial_out_load(serial_out_load),
  .serial_out_lsb_first(serial_out_lsb_first), .internal_bus(internal_bus), .accumulator_a(accumulator_a),
  .data_pointer(data_pointer));
`default_nettype wire

// ===== sim/dsp_instruction_field_decoder_test.sv
// Self-checking bench for the instruction decoder
`default_nettype none
module dsp_instruction_field_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and design outputs
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [23:0] instruction = 24'h000000;
  logic instr_valid = 1'b0, condition_true = 1'b0, alu_op_active = 1'b0, host_write = 1'b0, host_read = 1'b0;
  logic [15:0] rom_data = 16'h0000, alu_result = 16'h0000, host_wdata = 16'h0000, serial_in_word = 16'h0000;
  logic [3:0] serial_in_count = 4'h0;
  logic [10:0] program_counter;
  logic [9:0] rom_pointer;
  logic call_push, accumulator_select, alu_enable, host_request_flag, dma_request, serial_out_load;
  logic serial_out_lsb_first;
  logic [15:0] host_data_reg, serial_out_word, internal_bus, accumulator_a, accumulator_b;
  logic [15:0] factor_one, factor_two, status_reg;
  logic [7:0] data_pointer;
  int failures = 0, tests_run = 0;
  // Reference state, zero after reset
  logic [15:0] ma, mb, mtr, mtrb, mhd, mk, ml, mso;
  logic [10:0] mpc;
  logic [9:0] mrp;
  logic [7:0] mdp;
  logic mflag, mlsb, mcall;
  always #2.5 clk = ~clk;
  dsp_instruction_field_decoder dsp_instruction_field_decoder_i (.clk(clk), .rstn(rstn),
    .instruction(instruction), .instr_valid(instr_valid), .condition_true(condition_true),
    .program_counter(program_counter), .call_push(call_push), .rom_data(rom_data), .rom_pointer(rom_pointer),
    .alu_result(alu_result), .alu_op_active(alu_op_active), .accumulator_select(accumulator_select),
    .alu_enable(alu_enable), .host_write(host_write), .host_read(host_read), .host_wdata(host_wdata),
    .host_data_reg(host_data_reg), .host_request_flag(host_request_flag), .dma_request(dma_request),
    .serial_in_word(serial_in_word), .serial_in_count(serial_in_count), .serial_out_word(serial_out_word),
    .serial_out_load(serial_out_load), .serial_out_lsb_first(serial_out_lsb_first), .internal_bus(internal_bus),
    .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .factor_one(factor_one),
    .factor_two(factor_two), .status_reg(status_reg), .data_pointer(data_pointer));
  // ==========================================================================
  // Checking helpers
  task automatic chk(string nm, logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Registers land one cycle after their instruction
  task automatic chk_state();
    chk("pc", 16'(mpc), 16'(program_counter));
    chk("call", 16'(mcall), 16'(call_push));
    chk("acc_a", ma, accumulator_a);
    chk("acc_b", mb, accumulator_b);
    chk("dp", 16'(mdp), 16'(data_pointer));
    chk("rp", 16'(mrp), 16'(rom_pointer));
    chk("host", mhd, host_data_reg);
    chk("flag", 16'(mflag), 16'(host_request_flag));
    chk("dma", 16'h0000, 16'(dma_request));
    chk("k", mk, factor_one);
    chk("l", ml, factor_two);
    chk("so", mso, serial_out_word);
    chk("so_lsb", 16'(mlsb), 16'(serial_out_lsb_first));
  endtask
  // Model bus value; sign, status and RAM untested
  function automatic logic [15:0] src_val(logic [3:0] s);
    logic [15:0] r;
    case (s)
      4'h0: r = mtrb;
      4'h1: r = ma;
      4'h2: r = mb;
      4'h3: r = mtr;
      4'h4: r = 16'(mdp);
      4'h5: r = 16'(mrp);
      4'h6: r = rom_data;
      4'hB: for (int i = 0; i < 16; i++) r[i] = serial_in_word[15 - i];
      4'hC: r = serial_in_word;
      4'hD: r = mk;
      4'hE: r = ml;
      default: r = mhd;
    endcase
    return r;
  endfunction
  function automatic logic [23:0] pick();
    logic [3:0] s, d;
    logic [2:0] br [3] = '{3'h4, 3'h5, 3'h2};
    do s = 4'($urandom); while (s == 4'h7 || s == 4'hA || s == 4'hF);
    do d = 4'($urandom); while (d == 4'h7 || d == 4'hC || d == 4'hF);
    case ($urandom_range(0, 3))
      0: return {2'h2, br[$urandom_range(0, 2)], 6'($urandom), 11'($urandom), 2'h0};
      1: return {2'h3, 16'($urandom), 2'h0, d};
      default: return {2'h0, 6'h00, 8'($urandom), s, d};
    endcase
  endfunction
  // ==========================================================================
  // One instruction per cycle, back to back
  task automatic step(input logic [23:0] w);
    logic [15:0] v;
    logic [3:0] d;
    logic go;
    @(posedge clk);
    instruction <= w;
    instr_valid <= 1'b1;
    alu_op_active <= $urandom_range(0, 1);
    alu_result <= $urandom;
    rom_data <= $urandom;
    serial_in_word <= $urandom;
    condition_true <= $urandom_range(0, 1);
    #1;
    chk_state();
    d = w[3:0];
    v = w[23:22] == 2'h3 ? w[21:6] : src_val(w[7:4]);
    if (w[23:22] != 2'h2)
      chk("bus", v, internal_bus);
    go = w[23:22] == 2'h0 && alu_op_active && !((!w[15] && d == 4'h1) || (w[15] && d == 4'h2));
    chk("alu_en", 16'(go), 16'(alu_enable));
    mcall = w[23:22] == 2'h2 && w[21:19] == 3'h5;
    if (w[23:22] == 2'h2 && (w[21:19] == 3'h4 || mcall || (w[21:19] == 3'h2 && condition_true)))
      mpc = w[12:2];
    else
      mpc = mpc + 1'b1;
    if (w[23:22] == 2'h0)
    begin
      if (w[7:4] == 4'h8)
        mflag = 1'b1;
      if (go && w[15])
        mb = alu_result;
      if (go && !w[15])
        ma = alu_result;
      // A pointer move beats its modification
      if (d != 4'h4)
        mdp = {mdp[7:4] ^ w[12:9], w[14:13] == 2'h0 ? mdp[3:0] : w[14:13] == 2'h1 ? mdp[3:0] + 4'h1 :
          w[14:13] == 2'h2 ? mdp[3:0] - 4'h1 : 4'h0};
      if (d != 4'h5 && w[8])
        mrp = mrp - 1'b1;
    end
    if (w[23:22] != 2'h2)
      case (d)
        4'h1: ma = v;
        4'h2: mb = v;
        4'h3: mtr = v;
        4'h4: mdp = v[7:0];
        4'h5: mrp = v[9:0];
        4'h6: {mhd, mflag} = {v, 1'b1};
        4'h8, 4'h9: {mso, mlsb} = {v, d == 4'h8};
        4'hA: mk = v;
        4'hB: {mk, ml} = {v, rom_data};
        4'hD: ml = v;
        4'hE: mtrb = v;
        default: ;
      endcase
  endtask
  // Host access while the stream is idle
  task automatic host(input logic wr);
    @(posedge clk);
    instr_valid <= 1'b0;
    host_write <= wr;
    host_read <= !wr;
    host_wdata <= $urandom;
    @(posedge clk);
    host_write <= 1'b0;
    host_read <= 1'b0;
    if (wr)
      mhd = host_wdata;
    mflag = 1'b0;
    mcall = 1'b0;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    {ma, mb, mtr, mtrb, mhd, mk, ml, mso} = '0;
    {mpc, mrp, mdp, mflag, mlsb, mcall} = '0;
    void'($urandom(52734));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int n = 0; n < 600; n++)
      if ($urandom_range(0, 9) == 0)
        host($urandom_range(0, 1));
      else
        step(pick());
    end_sim();
  end
  initial
  begin
    #30000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
